// ### hw/mul_datapath.sv
// Purpose: execution datapath of the multiply_accumulator_by_file instruction
// Assumes: data memory answers a read in the same cycle
// Notes: one core clock per quarter phase
// Operation
// (RULE1) Multiply the working register by the addressed byte, both unsigned 8-bit.
// (RULE2) Write the whole 16-bit product to the product pair without truncation.
// (RULE3) Upper product byte goes to the high register, lower byte to the low register.
// (RULE4) Neither the working register nor the memory byte is written.
// (RULE5) No status flag changes, not even zero on a zero product.
// (RULE6) Carry and overflow are never reported.
// (RULE7) With bank mode bit 0 the operand goes through the access bank.
// (RULE8) With bank mode bit 1 the bank select pointer picks the register bank.
// (RULE9) Bank mode 0, extended set on and address up to 95 use indexed literal offset.
// (RULE10) One word, one cycle: decode Q1, read Q2, compute Q3, write products Q4.
`timescale 1ns/10ps
`default_nettype none
module mul_datapath
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // instruction issue
    input  wire logic        issue,
    input  wire logic [15:0] opcode,
    // core state
    input  wire logic [7:0]  w_value,
    input  wire logic [3:0]  bank_select_pointer,
    input  wire logic        ext_en,
    input  wire logic [11:0] index_base,
    // data memory
    output logic      [11:0] mem_addr,
    output logic             mem_rd,
    input  wire logic [7:0]  mem_rdata,
    output logic             mem_we,
    // results
    output logic [7:0]       product_high_byte,
    output logic [7:0]       product_low_byte,
    output logic             product_we,
    output logic             w_we,
    output logic             status_we,
    output logic             indexed_mode,
    output logic             phase_q1
);
    function automatic logic [15:0] umul8(input logic [7:0] a, input logic [7:0] b);
        umul8 = 16'(a) * 16'(b);
    endfunction : umul8

    logic             rst_meta;
    logic             rst_n;
    mul_pkg::phase_t  phase;
    logic             take;
    logic             in_q3;
    logic [7:0]       w_cap;
    logic [7:0]       op_cap;
    logic [15:0]      next_product;

    operand_addr_if addr_bus ();

    // reset release
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // quarter phase sequencer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            phase <= mul_pkg::q1;
        else
        begin
            unique case (phase)
                mul_pkg::q1: phase <= mul_pkg::q2;
                mul_pkg::q2: phase <= mul_pkg::q3;
                mul_pkg::q3: phase <= mul_pkg::q4;
                mul_pkg::q4: phase <= mul_pkg::q1;
            endcase
        end
    end

    assign phase_q1 = (phase == mul_pkg::q1);
    // decode in q1
    assign take = issue && phase_q1
                  && (opcode[15:mul_pkg::OPC_POS] == mul_pkg::OPC_MATCH);    // [RULE10]

    assign addr_bus.f                   = opcode[7:0];
    assign addr_bus.bank_mode           = opcode[mul_pkg::BANK_MODE_POS];
    assign addr_bus.bank_select_pointer = bank_select_pointer;
    assign addr_bus.ext_en              = ext_en;
    assign addr_bus.index_base          = index_base;

    operand_addr_former u_former
    (
        .port (addr_bus.former)
    );

    // operand address and read strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_addr     <= mul_pkg::ADDR_RESET;
            mem_rd       <= 1'b0;
            indexed_mode <= 1'b0;
        end
        else
        begin
            mem_rd <= take;                                                  // [RULE10]
            if (take)
            begin
                mem_addr     <= addr_bus.addr;                               // [RULE7] [RULE8]
                indexed_mode <= addr_bus.indexed;                            // [RULE9]
            end
        end
    end

    // operand capture in q2
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_cap  <= 8'h00;
            op_cap <= 8'h00;
            in_q3  <= 1'b0;
        end
        else
        begin
            in_q3 <= mem_rd;
            if (mem_rd)
            begin
                w_cap  <= w_value;
                op_cap <= mem_rdata;
            end
        end
    end

    // compute in q3
    assign next_product = umul8(w_cap, op_cap);                              // [RULE1]

    // product write in q4
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            product_high_byte <= mul_pkg::PRODUCT_RESET;
            product_low_byte  <= mul_pkg::PRODUCT_RESET;
            product_we        <= 1'b0;
        end
        else
        begin
            product_we <= in_q3;                                             // [RULE10]
            if (in_q3)
            begin
                product_high_byte <= next_product[15:8];                     // [RULE2] [RULE3]
                product_low_byte  <= next_product[7:0];                      // [RULE2] [RULE3]
            end
        end
    end

    // sources and flags never written
    assign w_we      = 1'b0;                                                 // [RULE4]
    assign mem_we    = 1'b0;                                                 // [RULE4]
    assign status_we = 1'b0;                                                 // [RULE5] [RULE6]

    sequence s_take;
        take;
    endsequence

    sequence s_read_then_write;
        mem_rd ##1 !mem_rd ##1 product_we;
    endsequence

    property p_full_product;
        @(posedge clk) disable iff (!rst_n)
        product_we |-> {product_high_byte, product_low_byte}
                       == 16'($past(w_cap)) * 16'($past(op_cap));
    endproperty
    a_full_product: assert property (p_full_product)                        // [RULE1] [RULE2]
        else $error("product differs from unsigned operand product");

    property p_byte_order;
        @(posedge clk) disable iff (!rst_n)
        in_q3 |=> (product_high_byte == $past(next_product[15:8]))
                  && (product_low_byte == $past(next_product[7:0]));
    endproperty
    a_byte_order: assert property (p_byte_order)                            // [RULE3]
        else $error("product bytes in wrong registers");

    property p_sources_kept;
        @(posedge clk) disable iff (!rst_n)
        s_take |-> (!w_we && !mem_we) [*4];
    endproperty
    a_sources_kept: assert property (p_sources_kept)                        // [RULE4]
        else $error("source operand written");

    property p_flags_kept;
        @(posedge clk) disable iff (!rst_n)
        (product_we && (product_high_byte == 8'h00) && (product_low_byte == 8'h00))
        |-> !status_we;
    endproperty
    a_flags_kept: assert property (p_flags_kept)                            // [RULE5] [RULE6]
        else $error("status written by multiply");

    property p_access_bank;
        @(posedge clk) disable iff (!rst_n)
        take && !opcode[mul_pkg::BANK_MODE_POS]
        && !(ext_en && opcode[7:0] <= mul_pkg::ACCESS_LIMIT)
        |=> mem_addr[7:0] == $past(opcode[7:0])
            && mem_addr[11:8] == (mem_addr[7:0] <= mul_pkg::ACCESS_LIMIT ? 4'h0 : 4'hf);
    endproperty
    a_access_bank: assert property (p_access_bank)                          // [RULE7]
        else $error("access bank address wrong");

    property p_banked;
        @(posedge clk) disable iff (!rst_n)
        take && opcode[mul_pkg::BANK_MODE_POS]
        |=> mem_addr == {$past(bank_select_pointer), $past(opcode[7:0])};
    endproperty
    a_banked: assert property (p_banked)                                    // [RULE8]
        else $error("banked address wrong");

    property p_indexed;
        @(posedge clk) disable iff (!rst_n)
        take && !opcode[mul_pkg::BANK_MODE_POS] && ext_en
        && (opcode[7:0] <= mul_pkg::ACCESS_LIMIT)
        |=> indexed_mode && mem_addr == 12'($past(index_base) + {4'h0, $past(opcode[7:0])});
    endproperty
    a_indexed: assert property (p_indexed)                                  // [RULE9]
        else $error("indexed literal offset address wrong");

    property p_q_sequence;
        @(posedge clk) disable iff (!rst_n)
        s_take |-> ##1 s_read_then_write ##1 (!product_we && phase_q1);
    endproperty
    a_q_sequence: assert property (p_q_sequence)                            // [RULE10]
        else $error("multiply did not finish in one instruction cycle");
endmodule : mul_datapath
`default_nettype wire

// ### hw/mul_pkg.sv
// Purpose: shared constants and types for the unsigned multiply datapath
// Assumes: 8-bit core, 12-bit data address, one-word instruction
// Notes: one core clock per quarter phase
package mul_pkg;
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 12;
    localparam int          OPCODE_W      = 16;
    localparam int          OPC_POS       = 9;
    localparam logic [6:0]  OPC_MATCH     = 7'h01;
    localparam int          BANK_MODE_POS = 8;
    localparam logic [7:0]  ACCESS_LIMIT  = 8'h5f;
    localparam logic [3:0]  ACCESS_LOW    = 4'h0;
    localparam logic [3:0]  ACCESS_HIGH   = 4'hf;
    localparam logic [7:0]  PRODUCT_RESET = 8'h00;
    localparam logic [11:0] ADDR_RESET    = 12'h000;

    typedef enum logic [1:0] {q1, q2, q3, q4} phase_t;
endpackage : mul_pkg

// ### hw/operand_addr_former.sv
// Purpose: forms the 12-bit data address of the file operand
// Assumes: inputs are stable during the decode phase
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
module operand_addr_former
(
    // address request
    operand_addr_if.former port
);
    always_comb
    begin
        port.indexed = 1'b0;
        if (port.bank_mode)
        begin
            // banked general purpose space
            port.addr = {port.bank_select_pointer, port.f};                  // [RULE8]
        end
        else if (port.ext_en && (port.f <= mul_pkg::ACCESS_LIMIT))
        begin
            // indexed literal offset
            port.indexed = 1'b1;
            port.addr    = 12'(port.index_base + {4'h0, port.f});            // [RULE9]
        end
        else if (port.f <= mul_pkg::ACCESS_LIMIT)
        begin
            port.addr = {mul_pkg::ACCESS_LOW, port.f};                       // [RULE7]
        end
        else
        begin
            port.addr = {mul_pkg::ACCESS_HIGH, port.f};                      // [RULE7]
        end
    end
endmodule : operand_addr_former
`default_nettype wire

// ### hw/operand_addr_if.sv
// Purpose: carries operand address request and result between modules
// Assumes: combinational use within one clock
// Notes: former side drives the address
`timescale 1ns/10ps
`default_nettype none
interface operand_addr_if;
    logic [7:0]  f;
    logic        bank_mode;
    logic [3:0]  bank_select_pointer;
    logic        ext_en;
    logic [11:0] index_base;
    logic [11:0] addr;
    logic        indexed;

    modport req    (output f, bank_mode, bank_select_pointer, ext_en, index_base,
                    input  addr, indexed);
    modport former (input  f, bank_mode, bank_select_pointer, ext_en, index_base,
                    output addr, indexed);
endinterface : operand_addr_if
`default_nettype wire

// ### tb/testbench.sv
// Purpose: self-checking bench for the unsigned multiply datapath
// Assumes: one core clock per quarter phase, operand answered in the read cycle
// Notes: integer model of product and operand address, xorshift stimulus
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk;
    logic        resetn;
    logic        issue;
    logic [15:0] opcode;
    logic [7:0]  w_value;
    logic [3:0]  bank_select_pointer;
    logic        ext_en;
    logic [11:0] index_base;
    logic [11:0] mem_addr;
    logic        mem_rd;
    logic [7:0]  mem_rdata;
    logic        mem_we;
    logic [7:0]  product_high_byte;
    logic [7:0]  product_low_byte;
    logic        product_we;
    logic        w_we;
    logic        status_we;
    logic        indexed_mode;
    logic        phase_q1;
    int          miscompares;
    int          tests_run;
    logic [31:0] seed;
    logic [31:0] r;

    mul_datapath DUT (.clk(clk), .resetn(resetn), .issue(issue), .opcode(opcode),
        .w_value(w_value), .bank_select_pointer(bank_select_pointer), .ext_en(ext_en),
        .index_base(index_base), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata), .mem_we(mem_we), .product_high_byte(product_high_byte),
        .product_low_byte(product_low_byte), .product_we(product_we), .w_we(w_we),
        .status_we(status_we), .indexed_mode(indexed_mode), .phase_q1(phase_q1));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rand

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    // next cycle in which the phase is q1, bounded
    task automatic wait_q1();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (phase_q1 !== 1'b1 && n < 8);
        if (phase_q1 !== 1'b1)
        begin
            miscompares++;
            stop_test();
        end
    endtask : wait_q1

    task automatic side_chk();
        chk("write_enables", 16'h0, 16'({mem_we, w_we, status_we}));
    endtask : side_chk

    task automatic run_op(input logic a, input logic [7:0] f, input logic [7:0] w,
                          input logic [7:0] d, input logic [3:0] bsp, input logic ex,
                          input logic [11:0] ib);
        logic [11:0] ea;
        logic        ix;
        logic [15:0] prod;
        ix = !a && ex && f <= 8'h5f;
        ea = a ? {bsp, f} : ix ? ib + {4'h0, f} : (f <= 8'h5f ? {4'h0, f} : {4'hf, f});
        prod = {8'h00, w} * {8'h00, d};
        wait_q1();
        issue = 1'b1;
        opcode = {7'h01, a, f};
        bank_select_pointer = bsp;
        ext_en = ex;
        index_base = ib;
        @(posedge clk);
        #1;
        r = next_rand();
        issue = 1'b0;
        opcode = r[15:0];
        bank_select_pointer = r[19:16];
        ext_en = r[20];
        index_base = r[31:20];
        mem_rdata = d;
        w_value = w;
        chk("mem_rd", 16'h1, 16'(mem_rd));
        chk("mem_addr", 16'(ea), 16'(mem_addr));
        chk("indexed_mode", 16'(ix), 16'(indexed_mode));
        chk("product_we", 16'h0, 16'(product_we));
        side_chk();
        @(posedge clk);
        #1;
        mem_rdata = ~d;
        w_value = ~w;
        chk("mem_rd", 16'h0, 16'(mem_rd));
        chk("product_we", 16'h0, 16'(product_we));
        @(posedge clk);
        #1;
        chk("product_we", 16'h1, 16'(product_we));
        chk("product", prod, {product_high_byte, product_low_byte});
        side_chk();
    endtask : run_op

    // issue outside q1 and a foreign opcode in q1 must leave no trace
    task automatic refuse();
        logic [15:0] held;
        held = {product_high_byte, product_low_byte};
        wait_q1();
        issue = 1'b1;
        opcode = {7'h02, 9'h1ab};
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            #1;
            if (i == 0)
                opcode = {7'h01, 9'h0aa};
            if (i == 3)
                issue = 1'b0;
            chk("mem_rd", 16'h0, 16'(mem_rd));
            chk("product_we", 16'h0, 16'(product_we));
        end
        chk("product", held, {product_high_byte, product_low_byte});
    endtask : refuse

    initial
    begin
        miscompares = 0;
        tests_run = 0;
        seed = 32'h8e8c;
        resetn = 1'b0;
        issue = 1'b0;
        opcode = 16'h0000;
        w_value = 8'h00;
        bank_select_pointer = 4'h0;
        ext_en = 1'b0;
        index_base = 12'h000;
        mem_rdata = 8'h00;
        repeat (6) @(posedge clk);
        #1;
        chk("product", 16'h0, {product_high_byte, product_low_byte});
        resetn = 1'b1;
        repeat (2) @(posedge clk);
        run_op(1'b1, 8'h12, 8'hc4, 8'hb5, 4'h3, 1'b0, 12'h000);
        run_op(1'b0, 8'h00, 8'h00, 8'h7e, 4'h5, 1'b0, 12'h123);
        run_op(1'b0, 8'h5f, 8'hff, 8'hff, 4'h1, 1'b0, 12'h456);
        run_op(1'b0, 8'h60, 8'h80, 8'h02, 4'h2, 1'b1, 12'h789);
        run_op(1'b0, 8'h5f, 8'h01, 8'h00, 4'h7, 1'b1, 12'hfb0);
        run_op(1'b1, 8'hff, 8'h10, 8'h10, 4'hf, 1'b1, 12'h0ff);
        refuse();
        for (int k = 0; k < 40; k++)
        begin
            r = next_rand();
            run_op(r[0], r[15:8], r[23:16], r[31:24], r[7:4], r[1], r[11:0]);
        end
        refuse();
        stop_test();
    end
endmodule : testbench
`default_nettype wire
